// *** iolg_pkg.sv ***
// Register map, field layout and reset values of the I/O line output and write guard.
`default_nettype none
package iolg_pkg;
  localparam int          LINES         = 32;
  localparam int          DATA_W        = 32;
  localparam int          OFFS_W        = 8;
  localparam int          IRQ_W         = 1;
  // Register byte offsets.
  localparam logic [7:0]  OFF_LINE_EN   = 8'h00;
  localparam logic [7:0]  OFF_LINE_DIS  = 8'h04;
  localparam logic [7:0]  OFF_LINE_STAT = 8'h08;
  localparam logic [7:0]  OFF_OUT_EN    = 8'h10;
  localparam logic [7:0]  OFF_OUT_DIS   = 8'h14;
  localparam logic [7:0]  OFF_OUT_STAT  = 8'h18;
  localparam logic [7:0]  OFF_FILT_EN   = 8'h20;
  localparam logic [7:0]  OFF_FILT_DIS  = 8'h24;
  localparam logic [7:0]  OFF_FILT_STAT = 8'h28;
  localparam logic [7:0]  OFF_SET_OUT   = 8'h30;
  localparam logic [7:0]  OFF_CLR_OUT   = 8'h34;
  localparam logic [7:0]  OFF_OUT_DATA  = 8'h38;
  localparam logic [7:0]  OFF_OWR_EN    = 8'hA0;
  localparam logic [7:0]  OFF_OWR_DIS   = 8'hA4;
  localparam logic [7:0]  OFF_OWR_STAT  = 8'hA8;
  localparam logic [7:0]  OFF_GUARD_MOD = 8'hE4;
  localparam logic [7:0]  OFF_GUARD_STA = 8'hE8;
  localparam logic [7:0]  OFF_INT_STAT  = 8'hF0;
  localparam logic [7:0]  OFF_INT_MASK  = 8'hF4;
  // Field positions.
  localparam int          GUARD_ON_BIT  = 0;
  localparam int          VIOL_FLAG_BIT = 0;
  localparam int          VIOL_SRC_LSB  = 8;
  localparam int          IRQ_VIOL_BIT  = 0;
  // Reset values.
  localparam logic [31:0] LINE_RST      = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage
`default_nettype wire

// *** iolg_irq.sv ***
// Sticky interrupt status with write-one-to-clear, a mask and one level interrupt.
`timescale 1ns/100ps
`default_nettype none
module iolg_irq
  import iolg_pkg::*;
#(
  parameter int W = IRQ_W
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] eventIn,
  input  wire logic         statusClrWr,
  input  wire logic [W-1:0] statusClrData,
  input  wire logic         maskWr,
  input  wire logic [W-1:0] maskData,
  output logic      [W-1:0] status_reg,
  output logic      [W-1:0] mask_reg,
  output logic              irq_reg
);
  logic [W-1:0] status_next;
  logic [W-1:0] mask_next;

  // A new event wins over a clear written in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (statusClrWr) begin
      status_next = status_next & ~statusClrData;
    end
    status_next = status_next | eventIn;
    mask_next = maskWr ? maskData : mask_reg;
  end

  // Status, mask and the registered interrupt level.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_reg <= '0;
      mask_reg   <= '0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= |(status_next & mask_next);
    end
  end
endmodule
`default_nettype wire

// *** iolg_io_line_guard.sv ***
// APB register block for line output data, output write disable and the write guard.
//
// Behaviour
// - While the guard-on bit is set, writes to guarded configuration registers change nothing.
// - A blocked write sets the violation flag and records the targeted offset as its source.
// - Any read of the guard status register clears the violation flag.
// - Line enable, line disable, output enable, output disable and filter enable are guarded.
// - The output write disable register takes writes only while the guard is off.
// - Writing one to a bit of the set-output register sets that line's output data.
// - Writing one to a bit of the output write disable register stops direct data writes.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module iolg_io_line_guard
  import iolg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [LINES-1:0]  lineOut,
  output logic      [LINES-1:0]  lineOutEnable,
  output logic      [LINES-1:0]  lineCtrlEnable,
  output logic      [LINES-1:0]  lineFilterEnable,
  output logic                   irq
);
  // Offsets whose writes the guard can block.
  // The filter disable and write enable registers are left unguarded on purpose.
  function automatic logic isGuarded(input logic [OFFS_W-1:0] a);
    isGuarded = (a == OFF_LINE_EN) || (a == OFF_LINE_DIS) ||
                (a == OFF_OUT_EN) || (a == OFF_OUT_DIS) ||
                (a == OFF_FILT_EN) || (a == OFF_OWR_DIS);
  endfunction

  // Offsets that answer without an error.
  function automatic logic isMapped(input logic [OFFS_W-1:0] a);
    isMapped = isGuarded(a) || (a == OFF_LINE_STAT) || (a == OFF_OUT_STAT) ||
               (a == OFF_FILT_DIS) || (a == OFF_FILT_STAT) || (a == OFF_SET_OUT) ||
               (a == OFF_CLR_OUT) || (a == OFF_OUT_DATA) || (a == OFF_OWR_EN) ||
               (a == OFF_OWR_STAT) || (a == OFF_GUARD_MOD) || (a == OFF_GUARD_STA) ||
               (a == OFF_INT_STAT) || (a == OFF_INT_MASK);
  endfunction

  logic [LINES-1:0]  line_en_reg;
  logic [LINES-1:0]  out_en_reg;
  logic [LINES-1:0]  filt_en_reg;
  logic [LINES-1:0]  out_data_reg;
  logic [LINES-1:0]  wr_mask_reg;
  logic              guard_on_reg;
  logic              viol_flag_reg;
  logic [OFFS_W-1:0] viol_src_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [DATA_W-1:0] read_next;
  logic [IRQ_W-1:0]  irqStatus;
  logic [IRQ_W-1:0]  irqMask;
  logic              irqLevel;
  logic [OFFS_W-1:0] offs;
  logic              upperZero;
  logic              hit;
  logic              setupPhase;
  logic              done;
  logic              wrDone;
  logic              rdDone;
  logic              blocked;
  logic              okWr;
  logic              fullWord;

  // Byte lanes other than a full word are treated as a full word write;
  // the line registers are all single-purpose 32-bit bit masks.
  // A write with every strobe bit low changes nothing at all.
  assign fullWord   = |pstrb;
  assign offs       = paddr[OFFS_W-1:0];
  assign upperZero  = (paddr[ADDR_W-1:OFFS_W] == '0);
  assign hit        = upperZero && isMapped(offs);
  assign setupPhase = psel && !penable;
  assign done       = psel && penable && pready_reg;
  assign wrDone     = done && pwrite && hit && fullWord;
  assign rdDone     = done && !pwrite && hit;
  assign blocked    = wrDone && guard_on_reg && isGuarded(offs);
  assign okWr       = wrDone && !blocked;

  // Read data selection; write-only offsets answer zero.
  // Reserved offsets and addresses above the map read as zero as well.
  always_comb begin
    read_next = ZERO_WORD;
    unique case (offs)
      OFF_LINE_STAT: read_next = line_en_reg;
      OFF_OUT_STAT:  read_next = out_en_reg;
      OFF_FILT_STAT: read_next = filt_en_reg;
      OFF_OUT_DATA:  read_next = out_data_reg;
      OFF_OWR_STAT:  read_next = wr_mask_reg;
      OFF_GUARD_MOD: read_next[GUARD_ON_BIT] = guard_on_reg;
      OFF_GUARD_STA: begin
        read_next[VIOL_FLAG_BIT] = viol_flag_reg;
        read_next[VIOL_SRC_LSB +: OFFS_W] = viol_src_reg;
      end
      OFF_INT_STAT:  read_next[IRQ_W-1:0] = irqStatus;
      OFF_INT_MASK:  read_next[IRQ_W-1:0] = irqMask;
      OFF_SET_OUT:   read_next = ZERO_WORD;
      OFF_OWR_DIS:   read_next = ZERO_WORD;
      default:       read_next = ZERO_WORD;
    endcase
    if (!upperZero) begin
      read_next = ZERO_WORD;
    end
  end

  // Slave handshake: the answer is prepared in the setup cycle so that the
  // access phase completes on its first edge from flip-flop outputs.
  // Read side effects are taken at that same edge, never in the setup cycle.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= ZERO_WORD;
    end else if (setupPhase) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !hit;
      prdata_reg  <= pwrite ? ZERO_WORD : read_next;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= ZERO_WORD;
    end
  end

  // Line enable state, guarded against writes.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      line_en_reg <= LINE_RST;
    end else if (okWr && offs == OFF_LINE_EN) begin
      line_en_reg <= line_en_reg | pwdata;
    end else if (okWr && offs == OFF_LINE_DIS) begin
      line_en_reg <= line_en_reg & ~pwdata;
    end
  end

  // Output enable state, guarded against writes.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_en_reg <= LINE_RST;
    end else if (okWr && offs == OFF_OUT_EN) begin
      out_en_reg <= out_en_reg | pwdata;
    end else if (okWr && offs == OFF_OUT_DIS) begin
      out_en_reg <= out_en_reg & ~pwdata;
    end
  end

  // Input filter enable; only the enable side is guarded.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      filt_en_reg <= LINE_RST;
    end else if (okWr && offs == OFF_FILT_EN) begin
      filt_en_reg <= filt_en_reg | pwdata;
    end else if (okWr && offs == OFF_FILT_DIS) begin
      filt_en_reg <= filt_en_reg & ~pwdata;
    end
  end

  // Output data: set and clear act on any line, direct writes only where allowed.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_data_reg <= LINE_RST;
    end else if (okWr && offs == OFF_SET_OUT) begin
      out_data_reg <= out_data_reg | pwdata;
    end else if (okWr && offs == OFF_CLR_OUT) begin
      out_data_reg <= out_data_reg & ~pwdata;
    end else if (okWr && offs == OFF_OUT_DATA) begin
      out_data_reg <= (out_data_reg & ~wr_mask_reg) | (pwdata & wr_mask_reg);
    end
  end

  // Direct-write permission mask; the disable side is refused under the guard.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_mask_reg <= LINE_RST;
    end else if (okWr && offs == OFF_OWR_EN) begin
      wr_mask_reg <= wr_mask_reg | pwdata;
    end else if (okWr && offs == OFF_OWR_DIS) begin
      wr_mask_reg <= wr_mask_reg & ~pwdata;
    end
  end

  // Guard mode bit; the mode register itself is never guarded, or the guard
  // could not be turned off again.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      guard_on_reg <= 1'b0;
    end else if (okWr && offs == OFF_GUARD_MOD) begin
      guard_on_reg <= pwdata[GUARD_ON_BIT];
    end
  end

  // Violation flag and source; a violation in the reading cycle wins over the clear.
  // Only the latest blocked write is remembered, so software that wants every
  // source must read the status after each violation.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      viol_flag_reg <= 1'b0;
      viol_src_reg  <= '0;
    end else if (blocked) begin
      viol_flag_reg <= 1'b1;
      viol_src_reg  <= offs;
    end else if (rdDone && offs == OFF_GUARD_STA) begin
      viol_flag_reg <= 1'b0;
    end
  end

  // The violation event feeds the sticky interrupt status; a clear written in
  // the same cycle as a new violation loses, so no event is missed.
  iolg_irq #(
    .W (IRQ_W)
  ) u_irq (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .eventIn       (blocked),
    .statusClrWr   (okWr && offs == OFF_INT_STAT),
    .statusClrData (pwdata[IRQ_W-1:0]),
    .maskWr        (okWr && offs == OFF_INT_MASK),
    .maskData      (pwdata[IRQ_W-1:0]),
    .status_reg    (irqStatus),
    .mask_reg      (irqMask),
    .irq_reg       (irqLevel)
  );

  // All outputs come straight from flip-flops.
  // The interrupt level is registered inside the interrupt block.
  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign lineOut          = out_data_reg;
  assign lineOutEnable    = out_en_reg;
  assign lineCtrlEnable   = line_en_reg;
  assign lineFilterEnable = filt_en_reg;
  assign irq              = irqLevel;

  // Checks on the register behaviour.
  // They share the bus clock and stand down while reset is high.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_guard_blocks_line: assert property (
    (wrDone && guard_on_reg && offs == OFF_LINE_EN) |=> $stable(line_en_reg))
    else $error("Guarded line enable write changed state.");

  chk_violation_records: assert property (
    (wrDone && guard_on_reg && isGuarded(offs)) |=>
      (viol_flag_reg && viol_src_reg == $past(offs)))
    else $error("Blocked write did not record a violation.");

  chk_status_read_clears: assert property (
    (rdDone && offs == OFF_GUARD_STA && !blocked) |=> !viol_flag_reg)
    else $error("Status read did not clear the violation flag.");

  chk_guard_out_dis: assert property (
    (wrDone && guard_on_reg && offs == OFF_OUT_DIS) |=>
      ($stable(out_en_reg) && viol_flag_reg))
    else $error("Guarded output disable write took effect.");

  chk_owdr_blocked: assert property (
    (wrDone && guard_on_reg && offs == OFF_OWR_DIS) |=> $stable(wr_mask_reg))
    else $error("Write disable register accepted a write under guard.");

  chk_set_output: assert property (
    (wrDone && offs == OFF_SET_OUT) |=>
      (out_data_reg == ($past(out_data_reg) | $past(pwdata))))
    else $error("Set-output write gave the wrong line data.");

  chk_owdr_clears_mask: assert property (
    (wrDone && !guard_on_reg && offs == OFF_OWR_DIS) |=>
      (wr_mask_reg == ($past(wr_mask_reg) & ~$past(pwdata))))
    else $error("Write disable did not clear the permission bits.");

  chk_wo_reads_zero: assert property (
    (setupPhase && !pwrite && upperZero && (offs == OFF_SET_OUT || offs == OFF_OWR_DIS))
      |=> (prdata == ZERO_WORD && pready))
    else $error("Write-only register read returned data.");

  // Reads of the write-only offsets must leave the line data and the write permission mask alone.
  chk_set_read_keeps: assert property (
    (rdDone && offs == OFF_SET_OUT) |=> $stable(out_data_reg))
    else $error("Set-output read changed the line data.");

  chk_owdr_read_keeps: assert property (
    (rdDone && offs == OFF_OWR_DIS) |=> $stable(wr_mask_reg))
    else $error("Write disable read changed the permission bits.");

  // Each guarded offset has its own check, so a gap in the decode of one
  // register cannot hide behind another.
  chk_guard_line_dis: assert property (
    (wrDone && guard_on_reg && offs == OFF_LINE_DIS) |=> $stable(line_en_reg))
    else $error("Guarded line disable write took effect.");

  chk_guard_out_en: assert property (
    (wrDone && guard_on_reg && offs == OFF_OUT_EN) |=> $stable(out_en_reg))
    else $error("Guarded output enable write took effect.");

  chk_guard_filter: assert property (
    (wrDone && guard_on_reg && offs == OFF_FILT_EN) |=> $stable(filt_en_reg))
    else $error("Guarded filter enable write took effect.");

  // Without the guard the same write must land, or the checks above would
  // also pass for a register that ignores every write.
  chk_guard_off_lands: assert property (
    (wrDone && !guard_on_reg && offs == OFF_LINE_EN) |=>
      (line_en_reg == ($past(line_en_reg) | $past(pwdata))))
    else $error("Unguarded line enable write was lost.");

  chk_violation_irq: assert property (
    blocked |=> irqStatus[IRQ_VIOL_BIT])
    else $error("Blocked write did not raise the interrupt status.");

  chk_set_zero_keeps: assert property (
    (okWr && offs == OFF_SET_OUT) |=>
      ((out_data_reg & ~$past(pwdata)) == ($past(out_data_reg) & ~$past(pwdata))))
    else $error("Set-output write changed a line written with zero.");

  chk_direct_write_mask: assert property (
    (okWr && offs == OFF_OUT_DATA) |=>
      ((out_data_reg & ~$past(wr_mask_reg)) == ($past(out_data_reg) & ~$past(wr_mask_reg))))
    else $error("Direct data write reached a line with writes disabled.");

  chk_unmapped_error: assert property (
    (setupPhase && !hit) |=> (pslverr && pready && prdata == ZERO_WORD))
    else $error("Unmapped access did not answer with an error.");

  // Scenarios the bench is meant to reach.
  cov_blocked_write: cover property (blocked);
  cov_direct_write: cover property (okWr && offs == OFF_OUT_DATA);
  cov_flag_cleared: cover property (viol_flag_reg ##1 !viol_flag_reg);
  cov_set_line: cover property (wrDone && offs == OFF_SET_OUT && pwdata != ZERO_WORD);
  cov_irq_raised: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// *** iolg_io_line_guard_tb.sv ***
// Self-checking testbench for the I/O line output and write guard register block.
`timescale 1ns/100ps
`default_nettype none
module iolg_io_line_guard_tb
  import iolg_pkg::*;
;
  // Forty-six transfers of three cycles each; the ceiling leaves ample margin.
  localparam int TIMEOUT_CYC = 4000;
  logic        sys_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] lineOut;
  logic [31:0] lineOutEnable;
  logic [31:0] lineCtrlEnable;
  logic [31:0] lineFilterEnable;
  logic        irq;
  logic [31:0] rdVal;
  logic        errSeen;
  logic [7:0]  guarded [6];
  int          fails;
  int          checkCount;
  int          cycles;

  iolg_io_line_guard #(.ADDR_W(12)) DUT (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lineOut(lineOut), .lineOutEnable(lineOutEnable),
    .lineCtrlEnable(lineCtrlEnable), .lineFilterEnable(lineFilterEnable), .irq(irq)
  );

  // Clock of 50 ns period.
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high at an edge.
  task automatic apb(input logic isWr, input logic [11:0] addr, input logic [31:0] data);
    int waitCnt;
    waitCnt = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= isWr;
    paddr   <= addr;
    pwdata  <= data;
    pstrb   <= 4'hF;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      waitCnt++;
    end while (pready !== 1'b1);
    rdVal   = prdata;
    errSeen = pslverr;
    check("pready wait", 32'(waitCnt), 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] data);
    apb(1'b1, {4'h0, off}, data);
  endtask

  task automatic rd(input logic [7:0] off, input logic [31:0] exp, input string what);
    apb(1'b0, {4'h0, off}, 32'h0);
    check(what, rdVal, exp);
  endtask

  // Outputs are sampled mid-cycle so the last write has settled.
  task automatic outs(input logic [31:0] o, input logic [31:0] oe, input logic [31:0] ce,
                      input logic [31:0] fe, input logic i);
    @(negedge sys_clk);
    check("lineOut", lineOut, o);
    check("lineOutEnable", lineOutEnable, oe);
    check("lineCtrlEnable", lineCtrlEnable, ce);
    check("lineFilterEnable", lineFilterEnable, fe);
    check("irq", {31'h0, irq}, {31'h0, i});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run through the usual report.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYC) begin
      fails++;
      $display("BAD cycle limit expected %0d seen %0d", TIMEOUT_CYC - 1, cycles);
      results();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {fails, checkCount, cycles} = '0;
    guarded = '{OFF_LINE_EN, OFF_LINE_DIS, OFF_OUT_EN, OFF_OUT_DIS, OFF_FILT_EN, OFF_OWR_DIS};
    reset = 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    outs(32'h0, 32'h0, 32'h0, 32'h0, 1'b0);
    rd(OFF_GUARD_STA, 32'h0, "guard status at reset");
    check("mapped read error", {31'h0, errSeen}, 32'h0);
    $display("test reset done");
    // Set-output bits: ones set, zeros leave lines alone, reads return zero.
    wr(OFF_SET_OUT, 32'h0000_00A5);
    outs(32'h0000_00A5, 32'h0, 32'h0, 32'h0, 1'b0);
    wr(OFF_SET_OUT, 32'h0F00_0000);
    outs(32'h0F00_00A5, 32'h0, 32'h0, 32'h0, 1'b0);
    rd(OFF_SET_OUT, 32'h0, "set output readback");
    outs(32'h0F00_00A5, 32'h0, 32'h0, 32'h0, 1'b0);
    $display("test set output done");
    // Direct data writes reach only lines whose permission was not withdrawn.
    wr(OFF_OWR_EN, 32'hFFFF_FFFF);
    wr(OFF_OWR_DIS, 32'h0000_000F);
    rd(OFF_OWR_STAT, 32'hFFFF_FFF0, "write permission");
    wr(OFF_OUT_DATA, 32'h0000_0000);
    outs(32'h0000_0005, 32'h0, 32'h0, 32'h0, 1'b0);
    rd(OFF_OWR_DIS, 32'h0, "write disable readback");
    rd(OFF_OWR_STAT, 32'hFFFF_FFF0, "permission after read");
    $display("test write disable done");
    // Unmapped addresses answer with an error and change nothing.
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped read error", {31'h0, errSeen}, 32'h1);
    check("unmapped read data", rdVal, 32'h0);
    apb(1'b1, 12'h130, 32'hFFFF_FFFF);
    check("unmapped write error", {31'h0, errSeen}, 32'h1);
    outs(32'h0000_0005, 32'h0, 32'h0, 32'h0, 1'b0);
    $display("test unmapped done");
    // Every guarded register refuses writes while the guard is on.
    wr(OFF_LINE_EN, 32'h0000_FFFF);
    wr(OFF_OUT_EN, 32'h0000_00FF);
    wr(OFF_FILT_EN, 32'h0000_0F00);
    wr(OFF_INT_MASK, 32'h0000_0001);
    outs(32'h5, 32'hFF, 32'hFFFF, 32'hF00, 1'b0);
    wr(OFF_GUARD_MOD, 32'h0000_0001);
    foreach (guarded[i]) begin
      wr(guarded[i], 32'hFFFF_FFFF);
      rd(OFF_GUARD_STA, {16'h0, guarded[i], 8'h01}, "guard status");
      apb(1'b0, {4'h0, OFF_GUARD_STA}, 32'h0);
      check("flag after read", {31'h0, rdVal[0]}, 32'h0);
      outs(32'h5, 32'hFF, 32'hFFFF, 32'hF00, 1'b1);
    end
    rd(OFF_OWR_STAT, 32'hFFFF_FFF0, "permission under guard");
    $display("test guard done");
    // The violation interrupt is sticky, cleared by a one and gated by the mask.
    wr(OFF_INT_STAT, 32'h0000_0001);
    outs(32'h5, 32'hFF, 32'hFFFF, 32'hF00, 1'b0);
    wr(OFF_INT_MASK, 32'h0000_0000);
    wr(OFF_OUT_DIS, 32'hFFFF_FFFF);
    outs(32'h5, 32'hFF, 32'hFFFF, 32'hF00, 1'b0);
    rd(OFF_INT_STAT, 32'h0000_0001, "masked status");
    wr(OFF_INT_STAT, 32'h0000_0001);
    rd(OFF_INT_STAT, 32'h0, "status cleared");
    // With the guard off, writes land again.
    wr(OFF_GUARD_MOD, 32'h0000_0000);
    wr(OFF_OUT_DIS, 32'h0000_000F);
    outs(32'h5, 32'hF0, 32'hFFFF, 32'hF00, 1'b0);
    wr(OFF_OWR_DIS, 32'h0000_00F0);
    rd(OFF_OWR_STAT, 32'hFFFF_FF00, "permission after guard");
    $display("test interrupt done");
    results();
  end
endmodule
`default_nettype wire
